// file: hdl/sap_pkg.sv
/*
 * Shared constants and address helpers for the SRAM bank port link
 * between the framework end and the algorithm end.
 * Assumes both ends run on the same sys_clk.
 */
package sap_pkg;
    // -------------------------------------------------------------------
    // widths
    // -------------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int DATA_W = 128;
    localparam int BE_W = 16;
    localparam int SEG_W = 10;
    localparam int MEM_AW = 6;
    // -------------------------------------------------------------------
    // segment geometry
    // -------------------------------------------------------------------
    localparam logic [4:0] SEG_LSB = 5'h0A;
    localparam logic [3:0] SEG_SEL_MAX = 4'h9;
    localparam logic [19:0] ADDR_ONES = 20'hFFFFF;
    // -------------------------------------------------------------------
    // timing counts, in sys_clk cycles, and return buffer depth, in entries
    // -------------------------------------------------------------------
    localparam int LAT_CYC = 10;
    localparam int LAT_STG = LAT_CYC - 1;
    localparam logic [2:0] RST_CYC = 3'h4;
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] FIFO_DEPTH_C = 4'h8;

    // low-address mask of a segment; sel 0 is 16KB, 9 is 8MB
    function automatic logic [19:0] seg_mask(input logic [3:0] sel);
        return ~(ADDR_ONES << (5'(sel) + SEG_LSB));
    endfunction : seg_mask

    function automatic logic [19:0] seg_addr(input logic [9:0] base,
                                             input logic [19:0] cnt,
                                             input logic [3:0] sel);
        logic [19:0] m;
        m = seg_mask(sel);
        return ({base, 10'h000} & ~m) | (cnt & m);
    endfunction : seg_addr

    function automatic logic seg_last(input logic [19:0] cnt, input logic [3:0] sel);
        return (cnt & seg_mask(sel)) == seg_mask(sel);
    endfunction : seg_last
endpackage : sap_pkg

// file: hdl/sap_if.sv
/*
 * Link between framework end (fw) and algorithm end (alg).
 * Assumes both ends clock on sys_clk; no clock travels in it.
 */
`timescale 1ns/1ps
`default_nettype none
interface sap_if;
    logic alg_reset_n;
    logic alg_done;
    logic [sap_pkg::SEG_W-1:0] bank0_segment_base;
    logic [sap_pkg::SEG_W-1:0] bank1_segment_base;
    logic bank0_read_cmd_valid;
    logic [sap_pkg::ADDR_W-1:0] bank0_read_address;
    logic [sap_pkg::DATA_W-1:0] bank0_read_word;
    logic bank0_read_word_valid;
    logic bank1_write_valid;
    logic [sap_pkg::ADDR_W-1:0] bank1_write_address;
    logic [sap_pkg::DATA_W-1:0] bank1_write_word;
    logic [sap_pkg::BE_W-1:0] bank1_write_byte_en;

    modport fw (
        output alg_reset_n, bank0_segment_base, bank1_segment_base,
        output bank0_read_word, bank0_read_word_valid,
        input alg_done, bank0_read_cmd_valid, bank0_read_address,
        input bank1_write_valid, bank1_write_address, bank1_write_word,
        input bank1_write_byte_en
    );
    modport alg (
        input alg_reset_n, bank0_segment_base, bank1_segment_base,
        input bank0_read_word, bank0_read_word_valid,
        output alg_done, bank0_read_cmd_valid, bank0_read_address,
        output bank1_write_valid, bank1_write_address, bank1_write_word,
        output bank1_write_byte_en
    );
endinterface : sap_if
`default_nettype wire

// file: hdl/sap_fifo.sv
/*
 * Parameterised FIFO with valid/ready on both sides and an occupancy count.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sap_fifo #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp_reg;
    logic [PW-1:0] rp_reg;
    logic [PW:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready = cnt_reg != (PW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data = mem[rp_reg];
    assign count = cnt_reg;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= (wp_reg == PW'(DEPTH-1)) ? '0 : PW'(wp_reg + 1'b1);
            end
            if (pop) begin
                rp_reg <= (rp_reg == PW'(DEPTH-1)) ? '0 : PW'(rp_reg + 1'b1);
            end
            cnt_reg <= (PW+1)'(cnt_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
        end
    end

    // storage has no reset: contents are qualified by the count
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end
endmodule : sap_fifo
`default_nettype wire

// file: hdl/sap_alg.sv
/*
 * Algorithm end: streams one segment of bank 0 through a buffer, applies a
 * key and writes the result segment to bank 1, then flags completion.
 * Assumes the framework end drives alg_reset_n on the same sys_clk.
 */
// What this block does
// - write strobe high when address/data/enables valid
// - read strobe with address; keep issuing bursts
// - at most one 16-byte read per cycle
// - read words return in order, valid-qualified
// - read latency nominally ten cycles
// - capture on valid strobe, never count latency
// - segments allow overlap with DMA loads (here dma loads to bank 0 are blocked while the algorithm is active)
// - segment is iteration memory, power of two
// - segment between 16KB and 8MB
// - segment base maps onto address bits 19:10
// - only bits matching segment size used
// - upper bits latched at reset, counter cleared
// - legal size, one segment per iteration
// - iteration runs from reset release to done
// - segment bases come from programmable register
// - each bank may have its own size
// - ports granted while algorithm active
// - bases moved before each run
`timescale 1ns/1ps
`default_nettype none
module sap_alg (
    input wire logic sys_clk,
    input wire logic nrst,
    sap_if.alg bus,
    input wire logic [3:0] seg_size_sel,
    input wire logic [3:0] out_size_sel,
    input wire logic [127:0] data_key,
    input wire logic user_pause,
    output logic busy
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        SAP_ST_IDLE = 2'b00,
        SAP_ST_RUN = 2'b01,
        SAP_ST_DONE = 2'b10
    } sap_alg_st_e;

    typedef struct packed {
        sap_alg_st_e st;
        logic [9:0] base_rd;
        logic [9:0] base_wr;
        logic [3:0] sel_rd;
        logic [3:0] sel_wr;
        logic [127:0] key;
        logic [19:0] rd_cnt;
        logic rd_all;
        logic [19:0] wr_cnt;
        logic [3:0] outst;
        logic cap_v;
        logic [127:0] cap_w;
        logic cmd_v;
        logic [19:0] cmd_a;
        logic wv;
        logic [19:0] wa;
        logic [127:0] ww;
        logic [15:0] wbe;
        logic done;
        logic busy;
    } sap_alg_s;

    sap_alg_s s_reg;
    sap_alg_s s_next;

    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [127:0] fifo_out_data;
    logic [3:0] fifo_count;
    logic cap_taken;
    logic issue;
    logic wfire;

    // -------------------------------------------------------------------
    // return buffer
    // -------------------------------------------------------------------
    sap_fifo #(
        .WIDTH(sap_pkg::DATA_W),
        .DEPTH(sap_pkg::FIFO_DEPTH)
    ) u_buf (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(s_reg.cap_v),
        .in_ready(fifo_in_ready),
        .in_data(s_reg.cap_w),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    function automatic logic [3:0] clamp_sel(input logic [3:0] sel);
        return (sel > sap_pkg::SEG_SEL_MAX) ? sap_pkg::SEG_SEL_MAX : sel;
    endfunction : clamp_sel

    assign cap_taken = s_reg.cap_v & fifo_in_ready;
    // credit: in flight plus buffered never exceeds buffer depth
    assign issue = (s_reg.st == SAP_ST_RUN) & ~s_reg.rd_all &
        ({1'b0, s_reg.outst} + {1'b0, fifo_count} < {1'b0, sap_pkg::FIFO_DEPTH_C});
    assign fifo_out_ready = (s_reg.st == SAP_ST_RUN) & ~user_pause;
    assign wfire = fifo_out_valid & fifo_out_ready;

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.cmd_v = 1'b0;
        s_next.wv = 1'b0;
        s_next.done = 1'b0;

        // input flop; words are taken only when the strobe says so
        s_next.cap_v = bus.bank0_read_word_valid | (s_reg.cap_v & ~fifo_in_ready);
        if (bus.bank0_read_word_valid) begin
            s_next.cap_w = bus.bank0_read_word;
        end
        s_next.outst = 4'(s_reg.outst + {3'h0, issue} - {3'h0, cap_taken});

        if (!bus.alg_reset_n) begin
            // held in reset: latch segment placement, clear counters
            s_next = '0;
            s_next.st = SAP_ST_RUN;
            s_next.base_rd = bus.bank0_segment_base;
            s_next.base_wr = bus.bank1_segment_base;
            s_next.sel_rd = clamp_sel(seg_size_sel);
            s_next.sel_wr = clamp_sel(out_size_sel);
            s_next.key = data_key;
        end else begin
            case (s_reg.st)
                SAP_ST_RUN: begin
                    if (issue) begin
                        // one command per cycle, back to back allowed
                        s_next.cmd_v = 1'b1;
                        s_next.cmd_a = sap_pkg::seg_addr(s_reg.base_rd, s_reg.rd_cnt,
                            s_reg.sel_rd);
                        if (sap_pkg::seg_last(s_reg.rd_cnt, s_reg.sel_rd)) begin
                            s_next.rd_all = 1'b1;
                        end else begin
                            s_next.rd_cnt = s_reg.rd_cnt + 20'h00001;
                        end
                    end
                    if (wfire) begin
                        s_next.wv = 1'b1;
                        s_next.wa = sap_pkg::seg_addr(s_reg.base_wr, s_reg.wr_cnt,
                            s_reg.sel_wr);
                        s_next.ww = fifo_out_data ^ s_reg.key;
                        s_next.wbe = 16'hFFFF;
                        if (sap_pkg::seg_last(s_reg.wr_cnt, s_reg.sel_wr)) begin
                            s_next.done = 1'b1;
                            s_next.st = SAP_ST_DONE;
                        end else begin
                            s_next.wr_cnt = s_reg.wr_cnt + 20'h00001;
                        end
                    end
                end
                SAP_ST_DONE: begin
                    // waits here until the next reset starts a new iteration
                    s_next.st = SAP_ST_DONE;
                end
                SAP_ST_IDLE: begin
                    s_next.st = SAP_ST_IDLE;
                end
                default: begin
                    s_next.st = SAP_ST_IDLE;
                end
            endcase
        end
        s_next.busy = (s_next.st == SAP_ST_RUN);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign bus.bank0_read_cmd_valid = s_reg.cmd_v;
    assign bus.bank0_read_address = s_reg.cmd_a;
    assign bus.bank1_write_valid = s_reg.wv;
    assign bus.bank1_write_address = s_reg.wa;
    assign bus.bank1_write_word = s_reg.ww;
    assign bus.bank1_write_byte_en = s_reg.wbe;
    assign bus.alg_done = s_reg.done;
    assign busy = s_reg.busy;
endmodule : sap_alg
`default_nettype wire

// file: hdl/sap_fw.sv
/*
 * Framework end: runs the algorithm reset/run sequence, owns the segment
 * base registers and two stand-in bank memories, grants the ports to the
 * algorithm while it runs and leaves them to the DMA port otherwise.
 * Assumes the algorithm end sits on the same sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module sap_fw (
    input wire logic sys_clk,
    input wire logic nrst,
    sap_if.fw bus,
    input wire logic sw_trigger,
    input wire logic base_load,
    input wire logic [9:0] base0_in,
    input wire logic [9:0] base1_in,
    input wire logic dma_wr_valid,
    input wire logic [5:0] dma_wr_addr,
    input wire logic [127:0] dma_wr_word,
    input wire logic [5:0] dma_rd_addr,
    output logic [127:0] dma_rd_word,
    output logic alg_active,
    output logic iter_done
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        SAP_FW_IDLE = 2'b00,
        SAP_FW_RESET = 2'b01,
        SAP_FW_RUN = 2'b10
    } sap_fw_st_e;

    typedef struct packed {
        sap_fw_st_e st;
        logic [2:0] rst_cnt;
        logic alg_rst_n;
        logic active;
        logic done_pulse;
        logic [9:0] base0;
        logic [9:0] base1;
        logic [sap_pkg::LAT_STG-1:0] lat_v;
        logic [sap_pkg::LAT_STG*sap_pkg::MEM_AW-1:0] lat_a;
        logic rvalid;
        logic [127:0] rword;
        logic [127:0] dword;
    } sap_fw_s;

    sap_fw_s s_reg;
    sap_fw_s s_next;

    // small stand-ins for the banks, indexed by low address bits only
    logic [127:0] bank0_mem [2**sap_pkg::MEM_AW];
    logic [127:0] bank1_mem [2**sap_pkg::MEM_AW];
    logic [5:0] lat_top;
    logic rd_take;

    assign lat_top = s_reg.lat_a[sap_pkg::LAT_STG*sap_pkg::MEM_AW-1 -: sap_pkg::MEM_AW];
    // commands count only while the algorithm owns the ports
    assign rd_take = bus.bank0_read_cmd_valid & s_reg.active;

    always_comb begin
        s_next = s_reg;
        s_next.done_pulse = 1'b0;
        // fixed pipeline: data shows LAT_CYC cycles after the command
        s_next.lat_v = {s_reg.lat_v[sap_pkg::LAT_STG-2:0], rd_take};
        s_next.lat_a = {s_reg.lat_a[(sap_pkg::LAT_STG-1)*sap_pkg::MEM_AW-1:0],
            bus.bank0_read_address[5:0]};
        s_next.rvalid = s_reg.lat_v[sap_pkg::LAT_STG-1];
        s_next.rword = bank0_mem[lat_top];
        s_next.dword = bank1_mem[dma_rd_addr];
        case (s_reg.st)
            SAP_FW_IDLE: begin
                if (base_load) begin
                    // moved between runs only, never under a running algorithm
                    s_next.base0 = base0_in;
                    s_next.base1 = base1_in;
                end
                if (sw_trigger) begin
                    s_next.st = SAP_FW_RESET;
                    s_next.rst_cnt = 3'h0;
                    s_next.alg_rst_n = 1'b0;
                end
            end
            SAP_FW_RESET: begin
                s_next.rst_cnt = s_reg.rst_cnt + 3'h1;
                if (s_reg.rst_cnt == sap_pkg::RST_CYC - 3'h1) begin
                    s_next.st = SAP_FW_RUN;
                    s_next.alg_rst_n = 1'b1;
                    s_next.active = 1'b1;
                end
            end
            SAP_FW_RUN: begin
                if (bus.alg_done) begin
                    s_next.st = SAP_FW_IDLE;
                    s_next.active = 1'b0;
                    s_next.alg_rst_n = 1'b0;
                    s_next.done_pulse = 1'b1;
                end
            end
            default: begin
                s_next.st = SAP_FW_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // -------------------------------------------------------------------
    // bank storage
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        // dma loads are blocked while the algorithm holds the ports
        if (dma_wr_valid && !s_reg.active) begin
            bank0_mem[dma_wr_addr] <= dma_wr_word;
        end
        if (bus.bank1_write_valid && s_reg.active) begin
            for (int b = 0; b < sap_pkg::BE_W; b++) begin
                if (bus.bank1_write_byte_en[b]) begin
                    bank1_mem[bus.bank1_write_address[5:0]][b*8 +: 8] <=
                        bus.bank1_write_word[b*8 +: 8];
                end
            end
        end
    end

    assign bus.alg_reset_n = s_reg.alg_rst_n;
    assign bus.bank0_segment_base = s_reg.base0;
    assign bus.bank1_segment_base = s_reg.base1;
    assign bus.bank0_read_word = s_reg.rword;
    assign bus.bank0_read_word_valid = s_reg.rvalid;
    assign dma_rd_word = s_reg.dword;
    assign alg_active = s_reg.active;
    assign iter_done = s_reg.done_pulse;
endmodule : sap_fw
`default_nettype wire

// file: verif/sap_chk.sv
/*
 * Checker for the bank port link between framework end and algorithm end.
 * Assumes it sits beside the link and shares its sys_clk and nrst.
 */
`timescale 1ns/1ps
`default_nettype none
module sap_chk (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic alg_reset_n,
    input wire logic alg_done,
    input wire logic [sap_pkg::SEG_W-1:0] bank0_segment_base,
    input wire logic [sap_pkg::SEG_W-1:0] bank1_segment_base,
    input wire logic bank0_read_cmd_valid,
    input wire logic [sap_pkg::ADDR_W-1:0] bank0_read_address,
    input wire logic bank0_read_word_valid,
    input wire logic bank1_write_valid,
    input wire logic [sap_pkg::ADDR_W-1:0] bank1_write_address,
    input wire logic [sap_pkg::BE_W-1:0] bank1_write_byte_en
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // -------------------------------------------------------------------
    // read port
    // -------------------------------------------------------------------
    chk_read_latency: assert property (
        bank0_read_cmd_valid && alg_reset_n |-> ##10 bank0_read_word_valid)
        else $error("read word did not return ten cycles after its command");
    chk_word_from_cmd: assert property (
        bank0_read_word_valid |-> $past(bank0_read_cmd_valid, 10) && $past(alg_reset_n, 10))
        else $error("read word valid without an accepted command");
    chk_read_top_bit: assert property (
        bank0_read_cmd_valid |-> bank0_read_address[19] == bank0_segment_base[9])
        else $error("read address left its segment");
    // -------------------------------------------------------------------
    // write port
    // -------------------------------------------------------------------
    chk_write_top_bit: assert property (
        bank1_write_valid |-> bank1_write_address[19] == bank1_segment_base[9])
        else $error("write address left its segment");
    chk_write_all_bytes: assert property (
        bank1_write_valid |-> bank1_write_byte_en == 16'hFFFF)
        else $error("write byte enables not all set");
    // -------------------------------------------------------------------
    // iteration control
    // -------------------------------------------------------------------
    chk_done_single: assert property (
        alg_done |=> !alg_done)
        else $error("done flag longer than one cycle");
    chk_done_halts: assert property (
        alg_done |=> !alg_reset_n [*4])
        else $error("algorithm not held in reset after done");
    chk_reset_quiet: assert property (
        !alg_reset_n && !$past(alg_reset_n) |->
            !bank0_read_cmd_valid && !bank1_write_valid && !alg_done)
        else $error("port activity while algorithm held in reset");
    chk_reset_length: assert property (
        $rose(alg_reset_n) |-> !$past(alg_reset_n, 2) && !$past(alg_reset_n, 4))
        else $error("algorithm reset shorter than four cycles");
    chk_bases_fixed: assert property (
        alg_reset_n && $past(alg_reset_n) |->
            $stable(bank0_segment_base) && $stable(bank1_segment_base))
        else $error("segment base moved during an iteration");
endmodule : sap_chk
`default_nettype wire

// file: verif/algorithm_sram_port_streaming_tb.sv
/*
 * Self-checking bench: both ends joined over the link; the return buffer is
 * filled through the algorithm end with writes stalled. Assumes hdl/ compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module algorithm_sram_port_streaming_tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic sw_trigger = 1'b0;
    logic base_load = 1'b0;
    logic [9:0] base0_in = 10'h000;
    logic [9:0] base1_in = 10'h000;
    logic dma_wr_valid = 1'b0;
    logic [5:0] dma_wr_addr = 6'h00;
    logic [127:0] dma_wr_word = 128'h0;
    logic [5:0] dma_rd_addr = 6'h00;
    logic [127:0] dma_rd_word;
    logic alg_active;
    logic iter_done;
    logic [3:0] size_sel = 4'h0;
    logic [127:0] key = 128'h0;
    logic user_pause = 1'b0;
    logic busy;
    logic [127:0] model [64];
    logic [148:0] exq [$];
    logic [127:0] rq [$];
    int failures = 0;
    int checked = 0;
    int ncmd = 0;
    int nrd = 0;
    int nwr = 0;

    always #50 sys_clk = ~sys_clk;

    sap_if i_sap_if ();
    sap_fw i_sap_fw (.sys_clk(sys_clk), .nrst(nrst), .bus(i_sap_if), .sw_trigger(sw_trigger),
        .base_load(base_load), .base0_in(base0_in), .base1_in(base1_in),
        .dma_wr_valid(dma_wr_valid), .dma_wr_addr(dma_wr_addr), .dma_wr_word(dma_wr_word),
        .dma_rd_addr(dma_rd_addr), .dma_rd_word(dma_rd_word), .alg_active(alg_active),
        .iter_done(iter_done));
    sap_alg i_sap_alg (.sys_clk(sys_clk), .nrst(nrst), .bus(i_sap_if),
        .seg_size_sel(size_sel), .out_size_sel(size_sel), .data_key(key),
        .user_pause(user_pause), .busy(busy));
    sap_chk i_sap_chk (.sys_clk(sys_clk), .nrst(nrst), .alg_reset_n(i_sap_if.alg_reset_n),
        .alg_done(i_sap_if.alg_done), .bank0_segment_base(i_sap_if.bank0_segment_base),
        .bank1_segment_base(i_sap_if.bank1_segment_base),
        .bank0_read_cmd_valid(i_sap_if.bank0_read_cmd_valid),
        .bank0_read_address(i_sap_if.bank0_read_address),
        .bank0_read_word_valid(i_sap_if.bank0_read_word_valid),
        .bank1_write_valid(i_sap_if.bank1_write_valid),
        .bank1_write_address(i_sap_if.bank1_write_address),
        .bank1_write_byte_en(i_sap_if.bank1_write_byte_en));

    task automatic check(input logic [148:0] seen, input logic [148:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // -------------------------------------------------------------------
    // one iteration; junk trigger, base load and dma write mid-run
    // -------------------------------------------------------------------
    task automatic run(input logic [3:0] sel, input logic [9:0] b0, input logic [9:0] b1);
        int n;
        int cnt;
        int c0;
        int r0;
        int w0;
        logic [19:0] m;
        n = 1024 << sel;
        m = 20'((1 << (10 + sel)) - 1);
        size_sel = sel;
        key = {$urandom, $urandom, $urandom, $urandom};
        base0_in = b0;
        base1_in = b1;
        base_load = 1'b1;
        @(posedge sys_clk);
        #1 base_load = 1'b0;
        for (int k = 0; k < n; k++) begin
            exq.push_back({k == n - 1, ({b1, 10'h000} & ~m) | (20'(k) & m), model[k % 64] ^ key});
            rq.push_back(model[k % 64]);
        end
        sw_trigger = 1'b1;
        user_pause = 1'b1;
        c0 = ncmd;
        r0 = nrd;
        w0 = nwr;
        cnt = 0;
        do begin
            @(posedge sys_clk);
            #1 sw_trigger = 1'b0;
            cnt++;
        end while (alg_active !== 1'b1 && cnt < 20);
        check(149'(cnt), 149'(5));
        check(149'(busy), 149'(1));
        // writes stalled: credit must stop the reads at the buffer depth
        repeat (40) @(posedge sys_clk);
        #1 check(149'(ncmd - c0), 149'(sap_pkg::FIFO_DEPTH));
        check(149'(nrd - r0), 149'(sap_pkg::FIFO_DEPTH));
        check(149'(nwr - w0), 149'(0));
        check(149'(alg_active), 149'(1));
        cnt = 0;
        while (iter_done !== 1'b1 && cnt < 20000) begin
            @(posedge sys_clk);
            #1 user_pause = 1'($urandom_range(0, 1));
            cnt++;
            sw_trigger = (cnt == 50);
            base_load = (cnt == 50);
            dma_wr_valid = (cnt == 50);
            base0_in = ~b0;
            base1_in = ~b1;
            dma_wr_addr = 6'h05;
            dma_wr_word = ~model[5];
        end
        if (cnt >= 20000) failures++;
        check(149'(exq.size()), 149'(0));
        repeat (8) @(posedge sys_clk);
        #1 check(149'(alg_active), 149'(0));
    endtask : run

    // -------------------------------------------------------------------
    // result monitors: link writes and read word returns
    // -------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (i_sap_if.bank1_write_valid === 1'b1 || i_sap_if.alg_done === 1'b1) begin
            check({i_sap_if.alg_done, i_sap_if.bank1_write_address, i_sap_if.bank1_write_word},
                exq.size() > 0 ? exq.pop_front() : 'x);
        end
        if (i_sap_if.bank0_read_cmd_valid === 1'b1) ncmd++;
        if (i_sap_if.bank1_write_valid === 1'b1) nwr++;
        if (i_sap_if.bank0_read_word_valid === 1'b1) begin
            nrd++;
            check(149'(i_sap_if.bank0_read_word),
                149'(rq.size() > 0 ? rq.pop_front() : 128'hx));
        end
    end

    initial begin
        #(100 * 40000);
        failures++;
        summarize();
    end

    initial begin
        void'($urandom(6651));
        repeat (5) @(posedge sys_clk);
        #1 nrst = 1'b1;
        // strobe held across the loop so it is never lowered and raised in one step
        dma_wr_valid = 1'b1;
        for (int i = 0; i < 64; i++) begin
            model[i] = {$urandom, $urandom, $urandom, $urandom};
            dma_wr_addr = 6'(i);
            dma_wr_word = model[i];
            @(posedge sys_clk);
            #1;
        end
        dma_wr_valid = 1'b0;
        run(4'h0, 10'h3FF, 10'h155);
        run(4'h1, 10'h2AB, 10'h3FF);
        foreach (model[i]) begin
            dma_rd_addr = 6'(i);
            @(posedge sys_clk);
            #1 check(149'(dma_rd_word), 149'(model[i] ^ key));
        end
        summarize();
    end
endmodule : algorithm_sram_port_streaming_tb
`default_nettype wire
